// file: logic/video_palette_cfg.svh
// Constants for the video palette and mode register bank.
// Assumes a single 100 MHz clock and a byte-wide host port.
`ifndef VIDEO_PALETTE_CFG_SVH
`define VIDEO_PALETTE_CFG_SVH

`define VP_IDX_MODE_ONE 5'h00
`define VP_IDX_MASK 5'h01
`define VP_IDX_BORDER 5'h02
`define VP_IDX_MODE_TWO 5'h03
`define VP_IDX_RESET 5'h04
`define VP_IDX_PALETTE_BASE 5'h10

`define VP_M1_HIGH_BW 0
`define VP_M1_GRAPHICS 1
`define VP_M1_MONO 2
`define VP_M1_VIDEO_EN 3
`define VP_M1_COLOUR16 4

`define VP_M2_BLINK_EN 1
`define VP_M2_TWO_COLOUR 3

`define VP_RST_ASYNC 0
`define VP_RST_SYNC 1

`define VP_MODE_ONE_RESET 5'h00
`define VP_MASK_RESET 4'hF
`define VP_BORDER_RESET 4'h0
`define VP_MODE_TWO_RESET 4'h0
`define VP_ARRAY_RESET_RESET 2'h0

`define VP_ST_DISPLAY 0
`define VP_ST_PEN_TRIG 1
`define VP_ST_PEN_SW_B 2
`define VP_ST_VRETRACE 3
`define VP_ST_DOT 4

`endif

// file: logic/video_palette_pkg.sv
// Types shared by the video palette register bank.
// Assumes the cfg header for all numeric constants.
`default_nettype none
package video_palette_pkg;
	typedef logic [3:0] colour_t;
	typedef logic [4:0] reg_index_t;
	typedef enum logic {
		TOGGLE_INDEX,
		TOGGLE_DATA
	} toggle_e;
endpackage
`default_nettype wire

// file: logic/colour_lookup_if.sv
// Carrier between the register bank and the colour lookup table.
// Assumes both ends share clock_i.
`default_nettype none
interface colour_lookup_if;
	logic wr_en;
	logic [3:0] wr_addr;
	video_palette_pkg::colour_t wr_data;
	logic [3:0] rd_addr;
	video_palette_pkg::colour_t rd_data;
	modport bank (output wr_en, output wr_addr, output wr_data, output rd_addr,
		input rd_data);
	modport table_side (input wr_en, input wr_addr, input wr_data, input rd_addr,
		output rd_data);
endinterface
`default_nettype wire

// file: logic/colour_lookup_table.sv
// Sixteen 4-bit colour entries, write only from the host side.
// Assumes write and read address come from the same clock domain.
`default_nettype none
module colour_lookup_table (
	input wire logic clock_i,
	input wire logic rst_b,
	colour_lookup_if.table_side lut
);
	video_palette_pkg::colour_t entry [16];

	always_ff @(posedge clock_i or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 16; i++) begin
				entry[i] <= 4'h0;
			end
		end else if (lut.wr_en) begin
			entry[lut.wr_addr] <= lut.wr_data;
		end
	end

	assign lut.rd_data = entry[lut.rd_addr];
endmodule
`default_nettype wire

// file: logic/video_palette_regs.sv
// Register bank and colour mapping of the video array on one host port.
// Assumes host strobes and video inputs are synchronous to clock_i.
// Summary of operation
// - Each port write without a port read flips toggle; index write selects, next write stores data.
// - Port read forces toggle to index state and returns status.
// - Indices 10h-1Fh select sixteen write-only 4-bit colour entries.
// - Mode one bit 0 selects high-bandwidth operation.
// - Mode one bit 1 selects graphics, clear selects text.
// - Mode one bit 2 removes chroma from composite, not direct colours.
// - Mode one bit 3 clear, with index below 10h, forces whole screen to border colour.
// - Zero mask bits force matching colour index bits to zero, except bit 3 in graphics with blink.
// - Border value bits map to blue, green, red, intensity.
// - Text with blink: bit 7 blink, 6-4 background, 3-0 foreground.
// - Text without blink: 7-4 background, 3-0 foreground.
// - Graphics with blink: index bit 3 is the blink clock.
// - Reset bit 0 stops memory cycles and tri-states the colour outputs.
// - Reset bit 1 halts memory cycles and stops outputs, no tri-state.
// - Masked colour code n selects entry at index 10h plus n.
// - Index 10h or above blanks video and shows addressed entry.
// - Status carries display, pen trigger, pen switch, retrace, dot.
`include "video_palette_cfg.svh"
`default_nettype none
module video_palette_regs (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic port_wr_i,
	input wire logic port_rd_i,
	input wire logic [7:0] port_wdata_i,
	output logic [7:0] port_rdata_o,
	input wire logic [3:0] pixel_code_i,
	input wire logic [7:0] attr_byte_i,
	input wire logic fg_pixel_i,
	input wire logic display_active_i,
	input wire logic vretrace_i,
	input wire logic blink_clock_i,
	input wire logic pen_trigger_i,
	input wire logic pen_switch_b_i,
	output logic [3:0] colour_o,
	output logic [3:0] colour_oe_o,
	output logic composite_mono_o,
	output logic high_bandwidth_select_o,
	output logic low_bandwidth_select_o,
	output logic graphics_mode_o,
	output logic colour16_mode_o,
	output logic two_colour_mode_o,
	output logic mem_cycle_en_o
);
	logic rst_meta;
	logic rst_b;
	video_palette_pkg::toggle_e toggle;
	video_palette_pkg::reg_index_t index;
	logic [4:0] mode_control_one;
	logic [3:0] palette_address_mask;
	logic [3:0] border_colour;
	logic [3:0] mode_control_two;
	logic [1:0] array_reset_control;
	logic [4:0] status;
	logic pen_meta;
	logic pen_sync;
	logic pen_sync_d;
	logic sw_meta;
	logic sw_sync;
	logic sw_sync_d;
	logic pen_latch;

	colour_lookup_if lut ();

	colour_lookup_table u_table (
		.clock_i(clock_i),
		.rst_b(rst_b),
		.lut(lut)
	);

	// Reset release through two flops
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_meta <= 1'b0;
			rst_b <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_b <= rst_meta;
		end
	end

	wire data_write = port_wr_i && (toggle == video_palette_pkg::TOGGLE_DATA);
	wire index_write = port_wr_i && (toggle == video_palette_pkg::TOGGLE_INDEX);
	wire palette_sel = index[4];
	wire async_rst = array_reset_control[`VP_RST_ASYNC];
	wire sync_rst = array_reset_control[`VP_RST_SYNC];
	wire graphics = mode_control_one[`VP_M1_GRAPHICS];
	wire blink_en = mode_control_two[`VP_M2_BLINK_EN];

	always_ff @(posedge clock_i or negedge rst_b) begin
		if (!rst_b) begin
			toggle <= video_palette_pkg::TOGGLE_INDEX;
		end else if (port_rd_i) begin
			toggle <= video_palette_pkg::TOGGLE_INDEX;
		end else if (port_wr_i) begin
			toggle <= (toggle == video_palette_pkg::TOGGLE_INDEX) ?
				video_palette_pkg::TOGGLE_DATA : video_palette_pkg::TOGGLE_INDEX;
		end
	end

	always_ff @(posedge clock_i or negedge rst_b) begin
		if (!rst_b) begin
			index <= 5'h00;
		end else if (index_write && !port_rd_i) begin
			index <= port_wdata_i[4:0];
		end
	end

	always_ff @(posedge clock_i or negedge rst_b) begin
		if (!rst_b) begin
			mode_control_one <= `VP_MODE_ONE_RESET;
			palette_address_mask <= `VP_MASK_RESET;
			border_colour <= `VP_BORDER_RESET;
			mode_control_two <= `VP_MODE_TWO_RESET;
			array_reset_control <= `VP_ARRAY_RESET_RESET;
		end else if (data_write && !port_rd_i) begin
			case (index)
				`VP_IDX_MODE_ONE: mode_control_one <= port_wdata_i[4:0];
				`VP_IDX_MASK: palette_address_mask <= port_wdata_i[3:0];
				`VP_IDX_BORDER: border_colour <= port_wdata_i[3:0];
				`VP_IDX_MODE_TWO: mode_control_two <= port_wdata_i[3:0];
				`VP_IDX_RESET: array_reset_control <= port_wdata_i[1:0];
				default: begin
				end
			endcase
		end
	end

	assign lut.wr_en = data_write && !port_rd_i && palette_sel;
	assign lut.wr_addr = index[3:0];
	assign lut.wr_data = port_wdata_i[3:0];

	// Pen inputs come from pins: three flops, a trigger rise counts when the last two differ (newer high, older low)
	always_ff @(posedge clock_i or negedge rst_b) begin
		if (!rst_b) begin
			pen_meta <= 1'b0;
			pen_sync <= 1'b0;
			pen_sync_d <= 1'b0;
			sw_meta <= 1'b1;
			sw_sync <= 1'b1;
			sw_sync_d <= 1'b1;
		end else begin
			pen_meta <= pen_trigger_i;
			pen_sync <= pen_meta;
			pen_sync_d <= pen_sync;
			sw_meta <= pen_switch_b_i;
			sw_sync <= sw_meta;
			sw_sync_d <= sw_sync;
		end
	end

	// Rising edge latches until system reset
	wire pen_rise = pen_sync && pen_sync_d == 1'b0;
	always_ff @(posedge clock_i or negedge rst_b) begin
		if (!rst_b) begin
			pen_latch <= 1'b0;
		end else if (pen_rise) begin
			pen_latch <= 1'b1;
		end
	end

	wire [3:0] masked_code = pixel_code_i & palette_address_mask;

	wire [3:0] text_bg = blink_en ? {1'b0, attr_byte_i[6:4]} : attr_byte_i[7:4];
	wire text_blank = blink_en && attr_byte_i[7] && blink_clock_i;
	wire [3:0] text_code = (fg_pixel_i && !text_blank) ? attr_byte_i[3:0] : text_bg;

	wire [3:0] gfx_code = blink_en ? {blink_clock_i, masked_code[2:0]} : masked_code;
	wire [3:0] text_masked = text_code & palette_address_mask;

	assign lut.rd_addr = palette_sel ? index[3:0] : (graphics ? gfx_code : text_masked);

	// border bits are B G R I
	wire [3:0] pixel_colour = (palette_sel || (mode_control_one[`VP_M1_VIDEO_EN]
		&& display_active_i)) ? lut.rd_data : border_colour;

	assign status[`VP_ST_DISPLAY] = display_active_i;
	assign status[`VP_ST_PEN_TRIG] = pen_latch;
	assign status[`VP_ST_PEN_SW_B] = sw_sync_d;
	assign status[`VP_ST_VRETRACE] = vretrace_i;
	assign status[`VP_ST_DOT] = colour_o[index[1:0]];

	always_ff @(posedge clock_i or negedge rst_b) begin
		if (!rst_b) begin
			port_rdata_o <= 8'h00;
		end else if (port_rd_i) begin
			port_rdata_o <= {3'h0, status};
		end
	end

	always_ff @(posedge clock_i or negedge rst_b) begin
		if (!rst_b) begin
			colour_o <= 4'h0;
			colour_oe_o <= 4'h0;
			mem_cycle_en_o <= 1'b0;
		end else begin
			colour_oe_o <= async_rst ? 4'h0 : 4'hF;
			mem_cycle_en_o <= !(async_rst || sync_rst);
			if (!async_rst && !sync_rst) begin
				colour_o <= pixel_colour;
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_b) begin
		if (!rst_b) begin
			high_bandwidth_select_o <= 1'b0;
			low_bandwidth_select_o <= 1'b1;
			graphics_mode_o <= 1'b0;
			composite_mono_o <= 1'b0;
			colour16_mode_o <= 1'b0;
			two_colour_mode_o <= 1'b0;
		end else begin
			high_bandwidth_select_o <= mode_control_one[`VP_M1_HIGH_BW];
			low_bandwidth_select_o <= !mode_control_one[`VP_M1_HIGH_BW];
			graphics_mode_o <= graphics;
			composite_mono_o <= mode_control_one[`VP_M1_MONO];
			colour16_mode_o <= mode_control_one[`VP_M1_COLOUR16];
			two_colour_mode_o <= mode_control_two[`VP_M2_TWO_COLOUR];
		end
	end
endmodule
`default_nettype wire

// file: testbench/video_host_model.sv
// Host model: single-cycle port writes and reads on the shared port.
// Assumes one caller process and clock_i shared with the bank.
`default_nettype none
module video_host_model (
	input wire logic clock_i,
	output logic port_wr_o,
	output logic port_rd_o,
	output logic [7:0] port_wdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		port_wr_o = 1'b0;
		port_rd_o = 1'b0;
		port_wdata_o = 8'h00;
	end
	task automatic sel(input logic [4:0] idx);
		@(posedge clock_i);
		port_wr_o <= 1'b1;
		port_wdata_o <= {3'h0, idx};
		@(posedge clock_i);
		port_wr_o <= 1'b0;
		port_wdata_o <= ~{3'h0, idx};
	endtask
	task automatic put(input logic [4:0] idx, input logic [7:0] val);
		@(posedge clock_i);
		port_wr_o <= 1'b1;
		port_wdata_o <= {3'h0, idx};
		@(posedge clock_i);
		port_wdata_o <= val;
		@(posedge clock_i);
		port_wr_o <= 1'b0;
		// Released bus shows the inverse so stale data cannot pass
		port_wdata_o <= ~val;
	endtask
	task automatic mode_two(input logic [7:0] v);
		put(5'h03, v & 8'h0A);
	endtask
	task automatic rd();
		@(posedge clock_i);
		port_rd_o <= 1'b1;
		@(posedge clock_i);
		port_rd_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// file: testbench/video_palette_chk.sv
// Port checker for the video palette register bank.
// Bound to every bank instance; sees its ports only.
`default_nettype none
module video_palette_chk (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic port_wr_i,
	input wire logic port_rd_i,
	input wire logic display_active_i,
	input wire logic vretrace_i,
	input wire logic [7:0] port_rdata_o,
	input wire logic [3:0] colour_o,
	input wire logic [3:0] colour_oe_o,
	input wire logic composite_mono_o,
	input wire logic high_bandwidth_select_o,
	input wire logic low_bandwidth_select_o,
	input wire logic graphics_mode_o,
	input wire logic colour16_mode_o,
	input wire logic two_colour_mode_o,
	input wire logic mem_cycle_en_o
);
	default clocking dc @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	AST_BW_PAIR: assert property (
		low_bandwidth_select_o == !high_bandwidth_select_o) else $error("bandwidth pair");
	AST_RD_HOLD: assert property (
		!port_rd_i |=> $stable(port_rdata_o)) else $error("read data moved");
	AST_RD_TOP: assert property (
		port_rd_i |=> port_rdata_o[7:5] == 3'h0) else $error("status top bits");
	AST_RD_LIVE: assert property (
		port_rd_i |=> port_rdata_o[0] == $past(display_active_i)
		&& port_rdata_o[3] == $past(vretrace_i)) else $error("status live bits");
	AST_OE_ALL: assert property (
		colour_oe_o == 4'h0 || colour_oe_o == 4'hF) else $error("split enables");
	AST_OE_MEM: assert property (
		colour_oe_o == 4'h0 |-> !mem_cycle_en_o) else $error("memory on while off");
	AST_FREEZE: assert property (
		(!mem_cycle_en_o && colour_oe_o == 4'hF) [*3] |-> $stable(colour_o))
		else $error("colour moved in sync reset");
	AST_MODES: assert property (
		!port_wr_i [*3] |-> $stable({composite_mono_o, graphics_mode_o, colour16_mode_o,
		two_colour_mode_o, high_bandwidth_select_o})) else $error("mode without write");
	AST_RST_OUT: assert property (
		$rose(rst_b_i) |-> colour_oe_o == 4'h0 && !mem_cycle_en_o) else $error("reset out");
endmodule
bind video_palette_regs video_palette_chk chk (.*);
`default_nettype wire

// file: testbench/video_palette_regs_tb.sv
// Self-checking bench for the video palette register bank.
// Assumes the host model and checker files are compiled first.
`default_nettype none
module video_palette_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i = 1'b0, rst_b_i = 1'b0, port_wr_i, port_rd_i, fg_pixel_i = 1'b0;
	logic display_active_i = 1'b0, vretrace_i = 1'b0, blink_clock_i = 1'b0;
	logic pen_trigger_i = 1'b0, pen_switch_b_i = 1'b1;
	logic [7:0] port_wdata_i, port_rdata_o, attr_byte_i = 8'h00;
	logic [3:0] pixel_code_i = 4'h0, colour_o, colour_oe_o, msk, brd;
	logic composite_mono_o, high_bandwidth_select_o, low_bandwidth_select_o;
	logic graphics_mode_o, colour16_mode_o, two_colour_mode_o, mem_cycle_en_o;
	logic [3:0] pal [16];
	// Display enable as the design sampled it at the last edge
	logic da_seen = 1'b0;
	int err_total = 0, checks_done = 0, cyc = 0;
	always #5 clock_i = ~clock_i;
	video_palette_regs uut (.*);
	video_host_model host (.clock_i(clock_i), .port_wr_o(port_wr_i), .port_rd_o(port_rd_i),
		.port_wdata_o(port_wdata_i));
	always @(posedge clock_i) begin
		da_seen <= display_active_i;
		display_active_i <= 1'($urandom);
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			complete_run();
		end
	end
	task automatic complete_run();
		if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	function automatic logic [3:0] want(input logic g, input logic b);
		logic [3:0] ix;
		if (g) ix = pixel_code_i & msk;
		else if (fg_pixel_i) ix = attr_byte_i[3:0] & msk;
		else if (b) ix = {1'b0, attr_byte_i[6:4]} & msk;
		else ix = attr_byte_i[7:4] & msk;
		if (g && b) ix[3] = blink_clock_i;
		return pal[ix];
	endfunction
	initial begin
		logic [7:0] b;
		logic [4:0] m1;
		logic [3:0] c;
		void'($urandom(87276));
		vretrace_i <= 1'($urandom);
		pen_switch_b_i <= 1'($urandom);
		msk = 4'hF;
		repeat (20) @(posedge clock_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		for (int i = 0; i < 16; i++) begin
			pal[i] = 4'($urandom);
			host.put(5'h10 + 5'(i), {4'h0, pal[i]});
		end
		settle(3);
		chk("lut view", {4'h0, colour_o}, {4'h0, pal[15]});
		host.rd();
		#1;
		chk("status", {4'h0, port_rdata_o[4:1]}, {4'h0, pal[15][3], vretrace_i,
			pen_switch_b_i, 1'b0});
		msk = 4'($urandom);
		brd = 4'($urandom);
		host.put(5'h01, {4'h0, msk});
		host.put(5'h02, {4'h0, brd});
		host.put(5'h00, 8'h02);
		settle(3);
		chk("border", {4'h0, colour_o}, {4'h0, brd});
		host.sel(5'h1A);
		host.rd();
		for (int i = 0; i < 8; i++) begin
			m1 = 5'($urandom) | 5'h08;
			m1[1] = i[0];
			b = 8'($urandom);
			b[1] = i[1];
			host.put(5'h00, {3'h0, m1});
			host.mode_two(b);
			settle(3);
			chk("modes", {2'h0, high_bandwidth_select_o, low_bandwidth_select_o, graphics_mode_o,
				composite_mono_o, colour16_mode_o, two_colour_mode_o},
				{2'h0, m1[0], !m1[0], m1[1], m1[2], m1[4], b[3]});
			repeat (4) begin
				@(posedge clock_i);
				pixel_code_i <= 4'($urandom);
				attr_byte_i <= 8'($urandom);
				fg_pixel_i <= 1'($urandom);
				blink_clock_i <= 1'($urandom) & m1[1];
				settle(2);
				chk("colour", {4'h0, colour_o},
					{4'h0, (da_seen ? want(m1[1], b[1]) : brd)});
			end
		end
		host.put(5'h04, 8'h01);
		settle(3);
		chk("async", {3'h0, colour_oe_o, mem_cycle_en_o}, 8'h00);
		host.put(5'h04, 8'h02);
		settle(3);
		c = colour_o;
		chk("sync", {3'h0, colour_oe_o, mem_cycle_en_o}, 8'h1E);
		@(posedge clock_i);
		pixel_code_i <= ~pixel_code_i;
		settle(3);
		chk("frozen", {4'h0, colour_o}, {4'h0, c});
		host.put(5'h04, 8'h00);
		settle(3);
		chk("run", {7'h0, mem_cycle_en_o}, 8'h01);
		@(posedge clock_i);
		pen_trigger_i <= 1'b1;
		settle(5);
		host.rd();
		#1;
		chk("pen trigger", {7'h0, port_rdata_o[1]}, 8'h01);
		complete_run();
	end
endmodule
`default_nettype wire
